// ### hdl/ssp_pkg.sv
// Constants shared by the synchronous serial port design files
package ssp_pkg;

   // Register offsets on the plain register port
   localparam logic [1:0] ADDR_CTRL = 2'h0;
   localparam logic [1:0] ADDR_STAT = 2'h1;
   localparam logic [1:0] ADDR_BUF  = 2'h2;
   localparam logic [1:0] ADDR_IRQ  = 2'h3;

   // Control register fields
   localparam int CTRL_WRITE_COLLISION_FLAG = 7;
   localparam int CTRL_OVF  = 6;
   localparam int CTRL_EN   = 5;
   localparam int CTRL_CKP  = 4;
   localparam int CTRL_MODE = 0;

   // Status register fields
   localparam int STAT_SMP   = 7;
   localparam int STAT_CKE   = 6;
   localparam int STAT_STOP  = 4;
   localparam int STAT_START = 3;
   localparam int STAT_BF    = 0;

   // Interrupt flag register fields
   localparam int IRQ_FLAG = 0;
   localparam int IRQ_EN   = 1;

   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] STAT_RESET = 8'h00;
   localparam logic [7:0] BUF_RESET  = 8'h00;

   // Mode select codes
   localparam logic [3:0] MODE_MASTER_DIV4 = 4'h0;
   localparam logic [3:0] MODE_SLAVE_SS    = 4'h4;
   localparam logic [3:0] MODE_SLAVE_NOSS  = 4'h5;
   localparam logic [3:0] MODE_I2C_7BIT    = 4'h6;
   localparam logic [3:0] MODE_I2C_10BIT   = 4'h7;
   localparam logic [3:0] MODE_I2C_FWMAST  = 4'hb;

   // Framing and timing counts
   localparam logic [3:0] BYTE_LAST    = 4'h7;
   localparam logic [3:0] BYTE_BITS    = 4'h8;
   localparam logic [3:0] ACK_SLOT     = 4'h9;
   localparam int         MASTER_DIV   = 4;
   localparam logic [1:0] MASTER_HALF  = 2'(MASTER_DIV / 2 - 1);
   localparam logic [4:0] MASTER_EDGES = 5'h10;

   // Receive states of the two-wire slave
   typedef enum logic [3:0] {
      I2C_IDLE = 4'b0001,
      I2C_BITS = 4'b0010,
      I2C_ACK  = 4'b0100,
      I2C_NACK = 4'b1000
   } ssp_i2c_e;

endpackage : ssp_pkg

// ### hdl/ssp_sync.sv
// Two-flip-flop synchroniser for the serial pin inputs
`timescale 1ns/1ps
`default_nettype none

module ssp_sync #(
   parameter int WIDTH = 3
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] d_in,
   output logic      [WIDTH-1:0] d_out
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } ssp_sync_s;

   ssp_sync_s s;
   ssp_sync_s n;

   // Meta stage feeds only the second stage
   always_comb begin
      n      = s;
      n.meta = d_in;
      n.sync = s.meta;
      if (!ce) begin
         n = s;
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign d_out = s.sync;

endmodule : ssp_sync

`default_nettype wire

// ### hdl/ssp_port.sv
// Synchronous serial port: SPI master/slave and two-wire slave receive
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Select gating acts only in mode 0100; select pin is an input.
// - Gated and select high: SPI logic held reset, data output released.
// - Any SPI reset, select high or port disabled, clears bit counter.
// - After SPI reset data output stays zero until a new buffer write.
// - Slave shifting runs from the external clock; eight bits set flag.
// - Buffer write while shifting is ignored and sets write collision.
// - Byte completing while buffer full sets overflow and is discarded.
// - Port enable hands clock and data pins to port, else to I/O.
// - Clock polarity sets the idle level, one high, zero low.
// - Mode 0000 master at clock/4, 0100 gated slave, 0101 ungated slave.
// - Master samples mid-bit or at bit end by sample phase.
// - Clock-edge bit picks the data-stable edge, swapped by polarity.
// - Two-wire mode is a slave with start and stop interrupts.
// - In two-wire mode sample phase drives the pad slew limiters.
// - Two-wire data sampled on clock rise, changed on clock fall.
// - Two-wire pins are open drain, driven only for acknowledge.
// - Start is data falling with clock high; stop is data rising.
// - Valid byte is acknowledged and copied from shift register to buffer.
// - Buffer full, overflow or firmware master: no ack or load, flag set.
// - Buffer read clears buffer full; overflow cleared by software write.
// - Shift register moves data most significant bit first.
// - Eight SPI bits move byte to buffer, set buffer full and flag.
module ssp_port (
   input  wire logic       CLK,
   input  wire logic       RESETN,
   input  wire logic       CE,
   input  wire logic [1:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic      [7:0] RDATA,
   input  wire logic       SCK_I,
   output logic            SCK_O,
   output logic            SCK_OE,
   input  wire logic       SDI_I,
   output logic            SDI_O,
   output logic            SDI_OE,
   output logic            SDO_O,
   output logic            SDO_OE,
   input  wire logic       SS_N_I,
   output logic            PINS_SERIAL,
   output logic            SLEW_LIMIT,
   output logic            PORT_IRQ,
   output logic            WAKE
);

   typedef struct packed {
      logic                write_collision_flag;
      logic                ov;
      logic                en;
      logic                clock_polarity;
      logic [3:0]          mode;
      logic                sample_phase;
      logic                cke;
      logic                stop_seen;
      logic                start_seen;
      logic                bf;
      logic [7:0]          buf_q;
      logic [7:0]          sr;
      logic [3:0]          cnt;
      logic                loaded;
      logic                sdo_q;
      logic                flag;
      logic                flag_en;
      logic [7:0]          rdata;
      logic                sck_prev;
      logic                sda_prev;
      logic                m_run;
      logic                m_sck;
      logic [1:0]          m_div;
      logic [4:0]          m_edge;
      logic                m_pend;
      ssp_pkg::ssp_i2c_e   i2c_st;
   } ssp_state_s;

   ssp_state_s s;
   ssp_state_s n;

   logic [2:0] pin_s;
   logic       sck_s;
   logic       sdi_s;
   logic       ss_s;
   logic       spi_rst;
   logic       busy;
   logic       sck_rise;
   logic       sck_fall;
   logic       edge_ev;
   logic       edge_rise;
   logic       sample_now;
   logic       shift_now;
   logic       complete;
   logic       bf_set;
   logic       i2c_on;
   logic       start_cond;
   logic       stop_cond;
   logic       ack_ok;
   logic       master_on;
   logic       slave_on;
   logic       gated;

   // Mode decode helpers
   function automatic logic is_master(input logic [3:0] m);
      is_master = (m == ssp_pkg::MODE_MASTER_DIV4);
   endfunction : is_master

   function automatic logic is_slave(input logic [3:0] m);
      is_slave = (m == ssp_pkg::MODE_SLAVE_SS) || (m == ssp_pkg::MODE_SLAVE_NOSS);
   endfunction : is_slave

   function automatic logic is_i2c(input logic [3:0] m);
      is_i2c = (m == ssp_pkg::MODE_I2C_7BIT) || (m == ssp_pkg::MODE_I2C_10BIT) ||
               (m == ssp_pkg::MODE_I2C_FWMAST);
   endfunction : is_i2c

   // Pin synchroniser for clock, data in and select
   ssp_sync #(
      .WIDTH (3)
   ) u_sync (
      .clk   (CLK),
      .rst_n (RESETN),
      .ce    (CE),
      .d_in  ({SS_N_I, SDI_I, SCK_I}),
      .d_out (pin_s)
   );

   assign sck_s = pin_s[0];
   assign sdi_s = pin_s[1];
   assign ss_s  = pin_s[2];

   // Next-state logic
   always_comb begin
      n          = s;
      sample_now = 1'b0;
      shift_now  = 1'b0;
      complete   = 1'b0;
      bf_set     = 1'b0;
      edge_ev    = 1'b0;
      edge_rise  = 1'b0;
      ack_ok     = 1'b0;
      sck_rise   = sck_s & ~s.sck_prev;
      sck_fall   = ~sck_s & s.sck_prev;
      n.sck_prev = sck_s;
      n.sda_prev = sdi_s;
      i2c_on     = s.en && is_i2c(s.mode);
      start_cond = i2c_on && sck_s && s.sck_prev && s.sda_prev && !sdi_s;
      stop_cond  = i2c_on && sck_s && s.sck_prev && !s.sda_prev && sdi_s;
      // gating only in mode 0100; select high holds SPI reset
      spi_rst = !s.en || ((s.mode == ssp_pkg::MODE_SLAVE_SS) && ss_s);
      busy    = !spi_rst && ((s.cnt != 4'h0) || s.m_run);

      // reset clears framing; output quiet until reload
      if (spi_rst) begin
         n.cnt    = 4'h0;
         n.loaded = 1'b0;
         n.sdo_q  = 1'b0;
         n.m_run  = 1'b0;
         n.m_pend = 1'b0;
      end

      // Register writes
      if (WR) begin
         unique case (ADDR)
            ssp_pkg::ADDR_CTRL: begin
               n.write_collision_flag = WDATA[ssp_pkg::CTRL_WRITE_COLLISION_FLAG];
               n.ov   = WDATA[ssp_pkg::CTRL_OVF];
               n.en   = WDATA[ssp_pkg::CTRL_EN];
               n.clock_polarity  = WDATA[ssp_pkg::CTRL_CKP];
               n.mode = WDATA[ssp_pkg::CTRL_MODE +: 4];
            end
            ssp_pkg::ADDR_STAT: begin
               n.sample_phase = WDATA[ssp_pkg::STAT_SMP];
               n.cke = WDATA[ssp_pkg::STAT_CKE];
            end
            ssp_pkg::ADDR_BUF: begin
               // write during a byte is dropped
               if (busy) begin
                  n.write_collision_flag = 1'b1;
               end else begin
                  n.sr     = WDATA;
                  n.sdo_q  = WDATA[7];
                  n.loaded = 1'b1;
                  if (s.en && is_master(s.mode)) begin
                     n.m_run  = 1'b1;
                     n.m_edge = 5'h00;
                     n.m_div  = 2'h0;
                     n.m_pend = 1'b0;
                  end
               end
            end
            ssp_pkg::ADDR_IRQ: begin
               n.flag    = WDATA[ssp_pkg::IRQ_FLAG];
               n.flag_en = WDATA[ssp_pkg::IRQ_EN];
            end
         endcase
      end

      if (RD && (ADDR == ssp_pkg::ADDR_BUF)) begin
         n.bf = 1'b0;
      end

      // master clock at a quarter of the module clock
      if (!spi_rst && is_master(s.mode) && s.m_run) begin
         if (s.m_div == ssp_pkg::MASTER_HALF) begin
            n.m_div = 2'h0;
            // delayed sample lands at the end of the bit
            if (s.m_pend) begin
               sample_now = 1'b1;
               n.m_pend   = 1'b0;
            end
            if (s.m_edge != ssp_pkg::MASTER_EDGES) begin
               n.m_sck   = ~s.m_sck;
               n.m_edge  = s.m_edge + 5'h01;
               edge_ev   = 1'b1;
               edge_rise = ~s.m_sck;
            end else begin
               n.m_run = 1'b0;
            end
         end else begin
            n.m_div = s.m_div + 2'h1;
         end
      end

      // slave edges come from the external clock
      if (!spi_rst && is_slave(s.mode)) begin
         edge_ev   = sck_rise | sck_fall;
         edge_rise = sck_rise;
      end

      // stable edge from clock-edge bit and polarity
      if (edge_ev) begin
         if (edge_rise == (s.cke ^ s.clock_polarity)) begin
            if (is_master(s.mode) && s.sample_phase) begin
               n.m_pend = 1'b1;
            end else begin
               sample_now = 1'b1;
            end
         end else begin
            shift_now = 1'b1;
         end
      end

      // shift in at the bottom, out from the top
      if (sample_now) begin
         n.sr = {n.sr[6:0], sdi_s};
         if (n.cnt == ssp_pkg::BYTE_LAST) begin
            n.cnt    = 4'h0;
            complete = 1'b1;
         end else begin
            n.cnt = n.cnt + 4'h1;
         end
      end
      if (shift_now) begin
         n.sdo_q = n.loaded & n.sr[7];
      end

      // full buffer keeps old byte; else load; flag set either way
      if (complete) begin
         if (n.bf) begin
            n.ov = 1'b1;
         end else begin
            n.buf_q = n.sr;
            bf_set  = 1'b1;
         end
         n.flag = 1'b1;
      end

      if (!i2c_on) begin
         n.i2c_st = ssp_pkg::I2C_IDLE;
         if (!s.en) begin
            n.start_seen = 1'b0;
            n.stop_seen  = 1'b0;
         end
      end else if (start_cond) begin
         // start: data falls while clock high
         n.i2c_st     = ssp_pkg::I2C_BITS;
         n.cnt        = 4'h0;
         n.start_seen = 1'b1;
         n.stop_seen  = 1'b0;
         n.flag       = 1'b1;
      end else if (stop_cond) begin
         // stop: data rises while clock high
         n.i2c_st     = ssp_pkg::I2C_IDLE;
         n.cnt        = 4'h0;
         n.start_seen = 1'b0;
         n.stop_seen  = 1'b1;
         n.flag       = 1'b1;
      end else begin
         unique case (s.i2c_st)
            ssp_pkg::I2C_IDLE: begin
               n.cnt = 4'h0;
            end
            ssp_pkg::I2C_BITS: begin
               // sample on rise, act on fall
               if (sck_rise && (s.cnt != ssp_pkg::BYTE_BITS)) begin
                  n.sr  = {s.sr[6:0], sdi_s};
                  n.cnt = s.cnt + 4'h1;
               end else if (sck_fall && (s.cnt == ssp_pkg::BYTE_BITS)) begin
                  n.cnt  = ssp_pkg::ACK_SLOT;
                  n.flag = 1'b1;
                  ack_ok = !n.bf && !s.ov && (s.mode != ssp_pkg::MODE_I2C_FWMAST);
                  if (ack_ok) begin
                     n.buf_q  = s.sr;
                     bf_set   = 1'b1;
                     n.i2c_st = ssp_pkg::I2C_ACK;
                  end else begin
                     // refuse: no ack, no load, flag still set
                     if (n.bf) begin
                        n.ov = 1'b1;
                     end
                     n.i2c_st = ssp_pkg::I2C_NACK;
                  end
               end
            end
            ssp_pkg::I2C_ACK, ssp_pkg::I2C_NACK: begin
               if (sck_fall) begin
                  n.cnt    = 4'h0;
                  n.i2c_st = ssp_pkg::I2C_BITS;
               end
            end
            default: begin
               n.i2c_st = ssp_pkg::I2C_IDLE;
            end
         endcase
      end

      // buffer full set by a completed byte, set wins over read
      if (bf_set) begin
         n.bf = 1'b1;
      end

      // master clock rests at the idle level
      if (!n.m_run) begin
         n.m_sck = n.clock_polarity;
      end

      // Read data, one cycle after the strobe
      n.rdata = 8'h00;
      if (RD) begin
         unique case (ADDR)
            ssp_pkg::ADDR_CTRL: n.rdata = {s.write_collision_flag, s.ov, s.en, s.clock_polarity, s.mode};
            ssp_pkg::ADDR_STAT: n.rdata = {s.sample_phase, s.cke, 1'b0, s.stop_seen,
                                           s.start_seen, 2'b00, s.bf};
            ssp_pkg::ADDR_BUF:  n.rdata = s.buf_q;
            ssp_pkg::ADDR_IRQ:  n.rdata = {6'h00, s.flag_en, s.flag};
         endcase
      end

      if (!CE) begin
         n = s;
      end
   end

   // State register
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         s        <= '0;
         s.i2c_st <= ssp_pkg::I2C_IDLE;
      end else begin
         s <= n;
      end
   end

   // Pin drive and status outputs
   assign master_on   = s.en && is_master(s.mode);
   assign slave_on    = s.en && is_slave(s.mode);
   assign gated       = (s.mode == ssp_pkg::MODE_SLAVE_SS) && ss_s;
   assign RDATA       = s.rdata;
   assign SCK_O       = s.m_sck;
   assign SCK_OE      = master_on;
   assign SDO_O       = s.sdo_q;
   // data output released while deselected; pins to port
   assign SDO_OE      = master_on || (slave_on && !gated);
   // open drain: only the low acknowledge is driven
   assign SDI_O       = 1'b0;
   assign SDI_OE      = s.en && is_i2c(s.mode) && (s.i2c_st == ssp_pkg::I2C_ACK);
   assign PINS_SERIAL = s.en;
   // slew limiters follow sample phase in two-wire mode
   assign SLEW_LIMIT  = s.en && is_i2c(s.mode) && s.sample_phase;
   assign PORT_IRQ    = s.flag;
   assign WAKE        = s.flag && s.flag_en;

   a_gate_tristate: assert property (@(posedge CLK) disable iff (!RESETN)
      (s.en && (s.mode == ssp_pkg::MODE_SLAVE_SS) && ss_s) |-> !SDO_OE)
      else $error("data output driven while deselected");

   a_reset_count: assert property (@(posedge CLK) disable iff (!RESETN)
      (CE && spi_rst) |=> (s.cnt == 4'h0) && !s.m_run)
      else $error("bit counter not cleared by reset");

   a_reload_needed: assert property (@(posedge CLK) disable iff (!RESETN)
      (CE && spi_rst && !(WR && (ADDR == ssp_pkg::ADDR_BUF))) |=> !s.loaded && !SDO_O)
      else $error("shift data valid without reload");

   a_write_collision_flag_set: assert property (@(posedge CLK) disable iff (!RESETN)
      (CE && WR && (ADDR == ssp_pkg::ADDR_BUF) && busy) |=> s.write_collision_flag && $stable(s.sr))
      else $error("collision not flagged");

   a_ovf_discard: assert property (@(posedge CLK) disable iff (!RESETN)
      (CE && complete && s.bf && !(RD && (ADDR == ssp_pkg::ADDR_BUF)))
      |=> s.ov && s.flag && $stable(s.buf_q))
      else $error("overflow byte not discarded");

   a_byte_done: assert property (@(posedge CLK) disable iff (!RESETN)
      (CE && complete && !s.bf) |=> s.bf && s.flag && (s.buf_q == $past(n.sr)))
      else $error("completed byte not loaded");

   a_pins_gpio: assert property (@(posedge CLK) disable iff (!RESETN)
      !s.en |-> !SCK_OE && !SDO_OE && !SDI_OE && !PINS_SERIAL)
      else $error("pins held while port disabled");

   a_idle_level: assert property (@(posedge CLK) disable iff (!RESETN)
      (!s.m_run && $stable(s.clock_polarity) && $past(!s.m_run)) |-> (SCK_O == s.clock_polarity))
      else $error("clock idle level wrong");

   a_master_len: assert property (@(posedge CLK) disable iff (!RESETN || !CE)
      (WR && (ADDR == ssp_pkg::ADDR_BUF) && !busy && master_on && !spi_rst)
      |=> s.m_run [*8] ##[24:28] !s.m_run)
      else $error("master byte length wrong");

   a_ack_drive: assert property (@(posedge CLK) disable iff (!RESETN)
      (CE && ack_ok && !start_cond && !stop_cond) |=> SDI_OE && s.bf && s.flag)
      else $error("acknowledge not driven");

   a_nack_flag: assert property (@(posedge CLK) disable iff (!RESETN)
      (CE && i2c_on && (s.i2c_st == ssp_pkg::I2C_BITS) && sck_fall && !start_cond
       && !stop_cond && (s.cnt == ssp_pkg::BYTE_BITS) && (s.bf || s.ov))
      |=> !SDI_OE && s.flag && $stable(s.buf_q))
      else $error("refused byte acknowledged");

   a_start_flag: assert property (@(posedge CLK) disable iff (!RESETN)
      (CE && start_cond) |=> s.flag && s.start_seen && (s.i2c_st == ssp_pkg::I2C_BITS))
      else $error("start not detected");

   a_read_clear: assert property (@(posedge CLK) disable iff (!RESETN)
      (CE && RD && (ADDR == ssp_pkg::ADDR_BUF) && !bf_set) |=> !s.bf)
      else $error("buffer read left full flag");

endmodule : ssp_port

`default_nettype wire

// ### tb/ssp_spi_master_model.sv
// SPI master model that drives the serial side of the port
`timescale 1ns/1ps
`default_nettype none

module ssp_spi_master_model #(
   parameter int HALF_NS  = 400,
   parameter int PHASE_NS = 37
) (
   output logic      sck,
   output logic      mosi,
   output logic      ss_n,
   input  wire logic miso
);
   // Idle bus: clock at rest, slave deselected
   initial begin
      sck  = 1'b0;
      mosi = 1'b1;
      ss_n = 1'b1;
   end

   task automatic sel(input logic v);
      #(HALF_NS + PHASE_NS) ss_n = v;
      #(HALF_NS);
   endtask : sel

   // MSB first, both sides sample on rise
   task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      #(PHASE_NS);
      for (int i = 7; i > 7 - n; i--) begin
         mosi = tx[i];
         #(HALF_NS) sck = 1'b1;
         rx = {rx[6:0], miso};
         #(HALF_NS) sck = 1'b0;
      end
      #(HALF_NS) mosi = ~mosi; // Released line shows inverse
   endtask : xfer
endmodule : ssp_spi_master_model
`default_nettype wire

// ### tb/ssp_port_bench.sv
// Self-checking bench for the synchronous serial port
`timescale 1ns/1ps
`default_nettype none

module ssp_port_bench;
   logic       clk, resetn, ce, wr, rd, sck, sdi, ss_n;
   logic [1:0] addr;
   logic [7:0] wdata, rdata, rx;
   logic       sck_o, sck_oe, sdi_oe, sdo_o, sdo_oe, pins, slew, irq, wake;
   int         failures;
   int         n_tests;

   ssp_port dut_u (.CLK(clk), .RESETN(resetn), .CE(ce), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .SCK_I(sck), .SCK_O(sck_o), .SCK_OE(sck_oe),
      .SDI_I(sdi), .SDI_O(), .SDI_OE(sdi_oe), .SDO_O(sdo_o), .SDO_OE(sdo_oe),
      .SS_N_I(ss_n), .PINS_SERIAL(pins), .SLEW_LIMIT(slew), .PORT_IRQ(irq), .WAKE(wake));

   ssp_spi_master_model mdl_u (.sck(sck), .mosi(sdi), .ss_n(ss_n), .miso(sdo_o));

   // 10 MHz clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic test_done();
      if (failures == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : test_done

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : wr_reg

   task automatic chk_reg(input logic [1:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 chk(rdata, exp);
   endtask : chk_reg

   task automatic wait_irq();
      int k;
      k = 0;
      while (irq !== 1'b1 && k < 40) begin
         @(posedge clk);
         k++;
      end
      if (k == 40) begin
         failures++;
         test_done();
      end
   endtask : wait_irq

   task automatic t_modes();
      logic [3:0] m [4] = '{4'h0, 4'h4, 4'h5, 4'h6};
      chk_reg(2'h0, 8'h00);
      chk_reg(2'h1, 8'h00);
      for (int i = 0; i < 4; i++) begin
         wr_reg(2'h0, {4'h2, m[i]});
         wr_reg(2'h1, {m[i] == 4'h6, 7'h00});
         repeat (4) @(posedge clk);
         chk({7'h0, sck_oe}, {7'h0, m[i] == 4'h0});
         chk({7'h0, sdo_oe}, {7'h0, m[i] == 4'h0 || m[i] == 4'h5});
         chk({7'h0, slew}, {7'h0, m[i] == 4'h6});
         chk({7'h0, pins, sdi_oe}, 8'h02);
      end
      wr_reg(2'h1, 8'h00);
      wr_reg(2'h0, 8'h30);
      repeat (4) @(posedge clk);
      chk({7'h0, sck_o}, 8'h01);
      wr_reg(2'h0, 8'h04);
      @(negedge clk);
      chk({7'h0, pins}, 8'h00);
      // Clock enable low: the write must not land
      ce <= 1'b0;
      wr_reg(2'h0, 8'h24);
      ce <= 1'b1;
      chk_reg(2'h0, 8'h04);
   endtask : t_modes

   // full byte exchange in gated slave mode
   task automatic t_rx();
      wr_reg(2'h0, 8'h24);
      wr_reg(2'h1, 8'h40);
      wr_reg(2'h3, 8'h02);
      mdl_u.sel(1'b0);
      wr_reg(2'h2, 8'ha5);
      mdl_u.xfer(8'h3c, 8, rx);
      wait_irq();
      mdl_u.sel(1'b1);
      chk(rx, 8'ha5);
      chk({7'h0, wake}, 8'h01);
      chk_reg(2'h1, 8'h41);
      chk_reg(2'h2, 8'h3c);
      chk_reg(2'h1, 8'h40);
   endtask : t_rx

   task automatic t_ovf();
      wr_reg(2'h3, 8'h02);
      mdl_u.sel(1'b0);
      mdl_u.xfer(8'h5a, 8, rx);
      chk(rx, 8'h00);
      wait_irq();
      wr_reg(2'h3, 8'h02);
      mdl_u.xfer(8'h77, 8, rx);
      wait_irq();
      mdl_u.sel(1'b1);
      chk_reg(2'h0, 8'h64);
      chk_reg(2'h2, 8'h5a);
      wr_reg(2'h0, 8'h24);
      chk_reg(2'h0, 8'h24);
   endtask : t_ovf

   task automatic t_write_collision_flag();
      wr_reg(2'h3, 8'h02);
      mdl_u.sel(1'b0);
      wr_reg(2'h2, 8'hc3);
      mdl_u.xfer(8'h00, 4, rx);
      wr_reg(2'h2, 8'h99);
      chk(rx, 8'h0c);
      chk_reg(2'h0, 8'ha4);
      mdl_u.sel(1'b1);
      chk({6'h0, sdo_oe, sdo_o}, 8'h00);
      wr_reg(2'h0, 8'h24);
      mdl_u.sel(1'b0);
      mdl_u.xfer(8'h81, 8, rx);
      wait_irq();
      mdl_u.sel(1'b1);
      chk(rx, 8'h00);
      chk_reg(2'h2, 8'h81);
   endtask : t_write_collision_flag

   // Watchdog against a hung run
   initial begin
      #2000000;
      failures++;
      test_done();
   end

   // Main sequence
   initial begin
      resetn   = 1'b0;
      ce       = 1'b1;
      addr     = 2'h0;
      wdata    = 8'h00;
      wr       = 1'b0;
      rd       = 1'b0;
      failures = 0;
      n_tests  = 0;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      t_modes();
      t_rx();
      t_ovf();
      t_write_collision_flag();
      test_done();
   end
endmodule : ssp_port_bench
`default_nettype wire
